// ### dv/oneshot_measure_timer16_tb_top.sv
// top bench for the one-shot / measurement timer: bus tasks, scenarios.
// assumes osmt_sig_src drives the input pin and the checker is bound.
`timescale 1ns/1ps
module oneshot_measure_timer16_tb_top;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_awvalid = 1'b0;
    logic i_wvalid = 1'b0;
    logic i_bready = 1'b0;
    logic i_arvalid = 1'b0;
    logic i_rready = 1'b0;
    logic i_prev_overflow = 1'b0;
    logic src_run = 1'b0;
    logic [3:0] i_awaddr = 4'h0;
    logic [3:0] i_araddr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [7:0] src_hi = 8'h01;
    logic [7:0] src_lo = 8'h01;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic o_pin, o_overflow, o_irq, tin;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    int errors = 0;
    int tests_run = 0;
    int irq_cnt = 0;
    int cyc = 0;
    osmt_timer i_osmt_timer (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(4'hf),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .i_timer_input_pin(tin),
        .i_prev_overflow(i_prev_overflow), .o_pulse_output_pin(o_pin),
        .o_overflow(o_overflow), .o_irq(o_irq));
    osmt_sig_src i_osmt_sig_src (.i_clk(i_clk), .i_run(src_run),
        .i_hi(src_hi), .i_lo(src_lo), .o_pin(tin));
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    task automatic end_of_test();
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // overflow test alone needs ~66k cycles
    always @(posedge i_clk) begin
        cyc++;
        if (o_irq === 1'b1) irq_cnt++;
        if (cyc == 90000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_ok(input logic got);
        chk16({15'h0, got}, 16'h0001);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d,
                      input logic [1:0] er);
        logic aw_d;
        logic w_d;
        logic aw_t;
        logic w_t;
        aw_d = 1'b0;
        w_d = 1'b0;
        i_awaddr <= a;
        i_wdata <= {16'h0, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        // ready is read at the falling edge, settled, as the next edge sees it
        while (!(aw_d && w_d)) begin
            @(negedge i_clk);
            aw_t = !aw_d && o_awready;
            w_t = !w_d && o_wready;
            @(posedge i_clk);
            if (aw_t) begin
                aw_d = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (w_t) begin
                w_d = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        @(negedge i_clk);
        while (o_bvalid !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        i_bready <= 1'b1;
        @(negedge i_clk);
        chk16({14'h0, o_bresp}, {14'h0, er});
        @(posedge i_clk);
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d,
                      output logic [1:0] r);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        @(negedge i_clk);
        while (o_arready !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        i_arvalid <= 1'b0;
        @(negedge i_clk);
        while (o_rvalid !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        i_rready <= 1'b1;
        @(negedge i_clk);
        d = o_rdata[15:0];
        r = o_rresp;
        @(posedge i_clk);
        i_rready <= 1'b0;
    endtask
    task automatic rdx(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk16(d, exp);
    endtask
    task automatic tick();
        i_prev_overflow <= 1'b1;
        @(posedge i_clk);
        i_prev_overflow <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic t_regs();
        logic [15:0] d;
        logic [1:0] r;
        rdx(osmt_pkg::OFF_CTRL, osmt_pkg::CTRL_RST);
        rdx(osmt_pkg::OFF_EVCTL, osmt_pkg::EVCTL_RST);
        rdx(osmt_pkg::OFF_RELOAD, osmt_pkg::RELOAD_RST);
        rd(4'h2, d, r);
        chk16({14'h0, r}, {14'h0, osmt_pkg::AXI_SLVERR});
        wr(osmt_pkg::OFF_COUNT, 16'h1234, osmt_pkg::AXI_SLVERR);
        rdx(osmt_pkg::OFF_COUNT, 16'h0000);
    endtask
    // reload control is set with the active-low run to show it is ignored
    task automatic t_oneshot(input logic p);
        logic [15:0] d;
        logic [1:0] r;
        int n0;
        n0 = irq_cnt;
        wr(osmt_pkg::OFF_RELOAD, 16'h0020, osmt_pkg::AXI_OKAY);
        wr(osmt_pkg::OFF_CTRL, {5'h0, p, 2'h0, p, 1'b1, 6'h09},
            osmt_pkg::AXI_OKAY);
        repeat (2) @(posedge i_clk);
        chk_ok(o_pin === !p);
        rd(osmt_pkg::OFF_COUNT, d, r);
        chk_ok(d > 16'h0000 && d < 16'h0020);
        rdx(osmt_pkg::OFF_CTRL, {5'h0, p, 2'h0, p, 1'b1, 6'h08});
        repeat (40) @(posedge i_clk);
        chk16(16'(irq_cnt - n0), 16'h0001);
        chk_ok(o_pin === p);
        rdx(osmt_pkg::OFF_COUNT, 16'h0020);
    endtask
    task automatic t_rst_stop();
        logic [15:0] d;
        logic [1:0] r;
        int n0;
        n0 = irq_cnt;
        wr(osmt_pkg::OFF_RELOAD, 16'h0100, osmt_pkg::AXI_OKAY);
        wr(osmt_pkg::OFF_CTRL, 16'h0049, osmt_pkg::AXI_OKAY);
        wr(osmt_pkg::OFF_RELOAD, 16'h0077, osmt_pkg::AXI_OKAY);
        wr(osmt_pkg::OFF_CTRL, 16'h004a, osmt_pkg::AXI_OKAY);
        d = 16'h0002;
        while (d[1]) rd(osmt_pkg::OFF_CTRL, d, r);
        chk16(d, 16'h0048);
        rdx(osmt_pkg::OFF_COUNT, 16'h0077);
        repeat (300) @(posedge i_clk);
        chk16(16'(irq_cnt - n0), 16'h0000);
        chk_ok(o_pin === 1'b0);
    endtask
    task automatic t_event();
        int n0;
        n0 = irq_cnt;
        wr(osmt_pkg::OFF_EVCTL, 16'h0080, osmt_pkg::AXI_OKAY);
        wr(osmt_pkg::OFF_RELOAD, 16'h0003, osmt_pkg::AXI_OKAY);
        wr(osmt_pkg::OFF_CTRL, 16'h0049, osmt_pkg::AXI_OKAY);
        repeat (3) tick();
        chk16(16'(irq_cnt - n0), 16'h0000);
        repeat (3) tick();
        chk16(16'(irq_cnt - n0), 16'h0001);
        wr(osmt_pkg::OFF_EVCTL, 16'h0000, osmt_pkg::AXI_OKAY);
    endtask
    // m is the count held at the closing edge: edge spacing minus one
    task automatic t_meas(input logic [1:0] e,
                          input int hi, lo, t1, t2, n2, m);
        logic [15:0] d;
        logic [1:0] r;
        int n0;
        wr(osmt_pkg::OFF_EVCTL, {9'h0, e, 5'h0},
            osmt_pkg::AXI_OKAY);
        wr(osmt_pkg::OFF_CTRL, 16'h001d, osmt_pkg::AXI_OKAY);
        n0 = irq_cnt;
        src_hi <= 8'(hi);
        src_lo <= 8'(lo);
        src_run <= 1'b1;
        repeat (t1) @(posedge i_clk);
        chk16(16'(irq_cnt - n0), 16'h0000);
        repeat (t2 - t1) @(posedge i_clk);
        chk16(16'(irq_cnt - n0), 16'(n2));
        rd(osmt_pkg::OFF_RELOAD, d, r);
        chk16(d, 16'(m));
        wr(osmt_pkg::OFF_RELOAD, 16'h1234, osmt_pkg::AXI_OKAY);
        rd(osmt_pkg::OFF_RELOAD, d, r);
        chk_ok(d != 16'h1234);
        wr(osmt_pkg::OFF_CTRL, 16'h001c, osmt_pkg::AXI_OKAY);
        n0 = irq_cnt;
        repeat (100) @(posedge i_clk);
        chk16(16'(irq_cnt - n0), 16'h0000);
        src_run <= 1'b0;
    endtask
    task automatic t_ovf();
        int n0;
        wr(osmt_pkg::OFF_EVCTL, 16'h0040, osmt_pkg::AXI_OKAY);
        wr(osmt_pkg::OFF_CTRL, 16'h001d, osmt_pkg::AXI_OKAY);
        n0 = irq_cnt;
        src_hi <= 8'h04;
        src_lo <= 8'h04;
        src_run <= 1'b1;
        repeat (4) @(posedge i_clk);
        src_run <= 1'b0;
        repeat (65600) @(posedge i_clk);
        chk16(16'(irq_cnt - n0), 16'h0002);
        rdx(osmt_pkg::OFF_RELOAD, 16'h0000);
        rdx(osmt_pkg::OFF_CTRL, 16'h001c);
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        t_regs();
        t_oneshot(1'b0);
        t_oneshot(1'b1);
        t_rst_stop();
        t_event();
        t_meas(osmt_pkg::EDGE_RISE, 20, 20, 35, 115, 2, 39);
        t_meas(osmt_pkg::EDGE_FALL, 20, 20, 35, 115, 2, 39);
        t_meas(osmt_pkg::EDGE_BOTH, 10, 30, 8, 35, 1, 9);
        t_ovf();
        end_of_test();
    end
endmodule

// ### dv/osmt_sig_src.sv
// osmt_sig_src: external square-wave source on the timer input pin.
// assumes the bench changes run and lengths only after a clock edge.
`timescale 1ns/1ps
module osmt_sig_src (
    // clock
    input wire logic i_clk,
    // wave control
    input wire logic i_run,
    input wire logic [7:0] i_hi,
    input wire logic [7:0] i_lo,
    // pin
    output logic o_pin
);
    logic [8:0] ph;
    // idle low between bursts: a stopped source never leaves the pin high
    always_ff @(posedge i_clk) begin
        if (!i_run) begin
            ph <= 9'h000;
            o_pin <= 1'b0;
        end else begin
            o_pin <= (ph < {1'b0, i_hi});
            if (ph == {1'b0, i_hi} + {1'b0, i_lo} - 9'h001)
                ph <= 9'h000;
            else
                ph <= ph + 9'h001;
        end
    end
endmodule

// ### dv/osmt_timer_chk.sv
// osmt_timer_chk: port-level assertions for the one-shot/measure timer.
// assumes it is bound to osmt_timer and sees only that module's ports.
`timescale 1ns/1ps
module osmt_timer_chk (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // register bus
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    // timer outputs
    input wire logic o_overflow,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_rd_taken;
        i_arvalid && o_arready;
    endsequence
    property p_wr_answer;
        s_wr_taken |=> o_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response missing");
    property p_rd_answer;
        s_rd_taken |=> o_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read response missing");
    property p_b_hold;
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_b_release;
        o_bvalid && i_bready |=> !o_bvalid;
    endproperty
    a_b_release: assert property (p_b_release) else $error("bvalid stuck");
    property p_w_block;
        o_bvalid |-> !o_awready && !o_wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write not held off");
    property p_ar_block;
        o_rvalid |-> !o_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read not held off");
    property p_irq_pulse;
        o_irq |=> !o_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("irq longer than one clock");
    property p_ovf_pulse;
        o_overflow |=> !o_overflow;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse)
        else $error("overflow longer than one clock");
    property p_ovf_irq;
        o_overflow |-> o_irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow without interrupt");
endmodule
bind osmt_timer osmt_timer_chk i_osmt_timer_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_rdata(o_rdata), .o_overflow(o_overflow),
    .o_irq(o_irq));

// ### rtl/osmt_pkg.sv
// osmt_pkg: register map, field positions and codes for the one-shot /
// measurement timer. assumes a 32-bit axi4-lite register slave.
package osmt_pkg;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_EVCTL = 4'h4;
    localparam logic [3:0] OFF_RELOAD = 4'h8;
    localparam logic [3:0] OFF_COUNT = 4'hc;
    // control register fields
    localparam int B_ENABLE = 0;
    localparam int B_RESET = 1;
    localparam int B_MODE_LO = 2;
    localparam int B_INPOL = 4;
    localparam int B_TOUT_EN = 6;
    localparam int B_RELOAD_CTL = 7;
    localparam int B_OUT_POL = 10;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h04df;
    // clock and event control fields
    localparam int B_EDGE_LO = 5;
    localparam int B_EVENT_SRC = 7;
    localparam logic [15:0] EVCTL_RST = 16'h0000;
    localparam logic [15:0] EVCTL_WMASK = 16'h00e0;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    // mode codes
    localparam logic [1:0] MODE_TIMER = 2'b00;
    localparam logic [1:0] MODE_EVENT = 2'b01;
    localparam logic [1:0] MODE_ONESHOT = 2'b10;
    localparam logic [1:0] MODE_MEASURE = 2'b11;
    // edge select codes
    localparam logic [1:0] EDGE_RISE = 2'b00;
    localparam logic [1:0] EDGE_FALL = 2'b01;
    localparam logic [1:0] EDGE_BOTH = 2'b10;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} osmt_state_t;
endpackage

// ### rtl/osmt_timer.sv
// osmt_timer: one 16-bit timer instance, one-shot and measurement modes,
// axi4-lite register slave. inputs are synchronous to i_clk.
//
// How it works
// - one-shot counts the interval once and raises a single interrupt.
// - start on enable set, or previous timer overflow while enable set.
// - enable bit clears itself one clock after a one-shot start.
// - one-shot loads reload at start, counts down; reload bit ignored.
// - one-shot stops at underflow and requests its interrupt there.
// - the reset bit also stops a one-shot run.
// - pulse output active while one-shot runs, inactive after stop.
// - new reload value loads on reset bit, otherwise at next underflow.
// - one-shot in event mode ticks on previous timer overflows.
// - count register reads the live counter value.
// - measurement counts clocks upward from zero to all ones.
// - each effective edge after the first copies count to reload, zeroes counter.
// - measurement interrupts per result and on overflow without result.
// - first effective edge after start raises no interrupt.
// - overflow before a measurement leaves reload reading zero.
// - reload register is read-only in measurement mode.
// - measuring begins at the first qualifying edge after enable.
// - measurement stops on reset bit, overflow or enable cleared.
// - pulse-width overflow writes zero to reload and clears enable.
// - pulse-width interrupt waits for both a rising and falling edge.
// - period mode counts between edges of one selected polarity.
// - mode field code 10 is one-shot, 11 is measurement.
// - reset bit stops, loads counter, clears enable, then self-clears.
// - output polarity select sets one-shot pulse active level.
`timescale 1ns/1ps
module osmt_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [3:0] i_awaddr,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [3:0] i_araddr,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // timer pins and chaining
    input wire logic i_timer_input_pin,
    input wire logic i_prev_overflow,
    output logic o_pulse_output_pin,
    output logic o_overflow,
    // interrupt to the embedded controller
    output logic o_irq
);
    logic [15:0] ctrl_r;
    logic [15:0] evctl_r;
    logic [15:0] reload_r;
    logic [15:0] cnt_r;
    osmt_pkg::osmt_state_t st_r;
    logic pin_d_r;
    logic prev_d_r;
    logic seen_rise_r;
    logic seen_fall_r;
    logic clr_en_r;
    logic irq_r;
    logic ovf_r;
    logic [1:0] mode;
    logic [1:0] edge_sel;
    logic pin_eff;
    logic rise;
    logic fall;
    logic eff_edge;
    logic prev_tick;
    logic tick;
    logic both_edges;
    logic wr_fire;
    logic rd_fire;
    logic aw_held_r;
    logic w_held_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [15:0] wval;
    logic os_start;
    logic os_underflow;
    logic ms_ovf;
    logic ms_result;
    logic sw_reset;

    assign mode = ctrl_r[osmt_pkg::B_MODE_LO +: 2];
    assign edge_sel = evctl_r[osmt_pkg::B_EDGE_LO +: 2];
    assign sw_reset = ctrl_r[osmt_pkg::B_RESET];
    assign pin_eff = i_timer_input_pin ~^ ctrl_r[osmt_pkg::B_INPOL];
    assign rise = pin_eff & ~pin_d_r;
    assign fall = ~pin_eff & pin_d_r;
    assign both_edges = (edge_sel == osmt_pkg::EDGE_BOTH);
    always_comb begin
        case (edge_sel)
            osmt_pkg::EDGE_RISE: eff_edge = rise;
            osmt_pkg::EDGE_FALL: eff_edge = fall;
            default: eff_edge = rise | fall;
        endcase
    end
    assign prev_tick = i_prev_overflow & ~prev_d_r;
    // event source selects the chained overflow as count tick
    assign tick = evctl_r[osmt_pkg::B_EVENT_SRC]
        ? prev_tick : 1'b1;

    // one-shot starts: enable set, and optionally wait for the chained event
    assign os_start = (mode == osmt_pkg::MODE_ONESHOT)
        && st_r == osmt_pkg::ST_IDLE
        && ctrl_r[osmt_pkg::B_ENABLE] && !sw_reset
        && (!evctl_r[osmt_pkg::B_EVENT_SRC] || prev_tick);
    assign os_underflow = (mode == osmt_pkg::MODE_ONESHOT)
        && st_r == osmt_pkg::ST_RUN
        && tick && cnt_r == osmt_pkg::CNT_ZERO && !sw_reset;
    // measurement events need enable, so a cleared enable stops at once
    assign ms_ovf = (mode == osmt_pkg::MODE_MEASURE)
        && st_r == osmt_pkg::ST_RUN && ctrl_r[osmt_pkg::B_ENABLE]
        && !eff_edge && cnt_r == osmt_pkg::CNT_MAX && !sw_reset;
    assign ms_result = (mode == osmt_pkg::MODE_MEASURE)
        && st_r == osmt_pkg::ST_RUN && ctrl_r[osmt_pkg::B_ENABLE]
        && eff_edge && !sw_reset;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_d_r <= 1'b0;
            prev_d_r <= 1'b0;
        end else begin
            pin_d_r <= pin_eff;
            prev_d_r <= i_prev_overflow;
        end
    end

    // axi4-lite slave: address and data taken in either order
    assign o_awready = !aw_held_r && !o_bvalid;
    assign o_wready = !w_held_r && !o_bvalid;
    assign wr_fire = (aw_held_r || i_awvalid) && (w_held_r || i_wvalid)
        && !o_bvalid;
    logic [3:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    assign wa = aw_held_r ? awaddr_r : i_awaddr;
    assign wd = w_held_r ? wdata_r : i_wdata;
    assign ws = w_held_r ? wstrb_r : i_wstrb;
    assign wval = {ws[1] ? wd[15:8] : 8'h00, ws[0] ? wd[7:0] : 8'h00};

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= osmt_pkg::AXI_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (wa[1:0] != 2'b00 || wa == osmt_pkg::OFF_COUNT)
                    ? osmt_pkg::AXI_SLVERR : osmt_pkg::AXI_OKAY;
            end else begin
                if (i_awvalid && o_awready) begin
                    aw_held_r <= 1'b1;
                    awaddr_r <= i_awaddr;
                end
                if (i_wvalid && o_wready) begin
                    w_held_r <= 1'b1;
                    wdata_r <= i_wdata;
                    wstrb_r <= i_wstrb;
                end
                if (o_bvalid && i_bready) begin
                    o_bvalid <= 1'b0;
                end
            end
        end
    end

    assign o_arready = !o_rvalid;
    assign rd_fire = i_arvalid && o_arready;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= osmt_pkg::AXI_OKAY;
        end else if (rd_fire) begin
            o_rvalid <= 1'b1;
            o_rresp <= osmt_pkg::AXI_OKAY;
            case (i_araddr)
                osmt_pkg::OFF_CTRL: o_rdata <= {16'h0000, ctrl_r};
                osmt_pkg::OFF_EVCTL: o_rdata <= {16'h0000, evctl_r};
                osmt_pkg::OFF_RELOAD: o_rdata <= {16'h0000, reload_r};
                osmt_pkg::OFF_COUNT: o_rdata <= 32'(cnt_r);
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= osmt_pkg::AXI_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // control register; hardware clears of enable and reset win over writes
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_r <= osmt_pkg::CTRL_RST;
            evctl_r <= osmt_pkg::EVCTL_RST;
            clr_en_r <= 1'b0;
        end else begin
            clr_en_r <= os_start;
            if (wr_fire && wa == osmt_pkg::OFF_CTRL) begin
                ctrl_r <= wval & osmt_pkg::CTRL_WMASK;
            end
            if (wr_fire && wa == osmt_pkg::OFF_EVCTL) begin
                evctl_r <= wval & osmt_pkg::EVCTL_WMASK;
            end
            if (sw_reset) begin
                // reset takes one clock, then both bits drop
                ctrl_r[osmt_pkg::B_RESET] <= 1'b0;
                ctrl_r[osmt_pkg::B_ENABLE] <= 1'b0;
            end
            if (clr_en_r) begin
                ctrl_r[osmt_pkg::B_ENABLE] <= 1'b0;
            end
            if (ms_ovf && both_edges) begin
                ctrl_r[osmt_pkg::B_ENABLE] <= 1'b0;
            end
        end
    end

    // reload register: software value, or the latest measurement result
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            reload_r <= osmt_pkg::RELOAD_RST;
        end else if (ms_result) begin
            reload_r <= cnt_r;
        end else if (ms_ovf) begin
            reload_r <= osmt_pkg::CNT_ZERO;
        end else if (wr_fire && wa == osmt_pkg::OFF_RELOAD
            && mode != osmt_pkg::MODE_MEASURE) begin
            reload_r <= wval;
        end
    end

    // counter and run state
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= osmt_pkg::ST_IDLE;
            cnt_r <= osmt_pkg::CNT_ZERO;
            seen_rise_r <= 1'b0;
            seen_fall_r <= 1'b0;
        end else if (sw_reset) begin
            st_r <= osmt_pkg::ST_IDLE;
            cnt_r <= reload_r;
            seen_rise_r <= 1'b0;
            seen_fall_r <= 1'b0;
        end else begin
            case (st_r)
                osmt_pkg::ST_IDLE: begin
                    if (os_start) begin
                        st_r <= osmt_pkg::ST_RUN;
                        cnt_r <= reload_r;
                    end else if (mode == osmt_pkg::MODE_MEASURE
                        && ctrl_r[osmt_pkg::B_ENABLE]) begin
                        st_r <= osmt_pkg::ST_ARMED;
                    end
                end
                osmt_pkg::ST_ARMED: begin
                    if (!ctrl_r[osmt_pkg::B_ENABLE]
                        || mode != osmt_pkg::MODE_MEASURE) begin
                        st_r <= osmt_pkg::ST_IDLE;
                    end else if (eff_edge) begin
                        st_r <= osmt_pkg::ST_RUN;
                        cnt_r <= osmt_pkg::CNT_ZERO;
                        seen_rise_r <= rise;
                        seen_fall_r <= fall;
                    end
                end
                osmt_pkg::ST_RUN: begin
                    if (mode == osmt_pkg::MODE_ONESHOT) begin
                        if (os_underflow) begin
                            st_r <= osmt_pkg::ST_IDLE;
                            // a reload written mid-run takes effect here
                            cnt_r <= reload_r;
                        end else if (tick) begin
                            cnt_r <= cnt_r - 16'h0001;
                        end
                    end else if (mode == osmt_pkg::MODE_MEASURE
                        && ctrl_r[osmt_pkg::B_ENABLE]) begin
                        if (ms_ovf) begin
                            st_r <= osmt_pkg::ST_IDLE;
                        end else if (eff_edge) begin
                            cnt_r <= osmt_pkg::CNT_ZERO;
                            seen_rise_r <= seen_rise_r | rise;
                            seen_fall_r <= seen_fall_r | fall;
                        end else begin
                            cnt_r <= cnt_r + 16'h0001;
                        end
                    end else begin
                        st_r <= osmt_pkg::ST_IDLE;
                    end
                end
                default: st_r <= osmt_pkg::ST_IDLE;
            endcase
        end
    end

    // interrupt and chained overflow pulses, one clock each
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            irq_r <= os_underflow
                || ms_ovf
                || (ms_result && (!both_edges
                    || ((seen_rise_r | rise) && (seen_fall_r | fall))));
            ovf_r <= os_underflow || ms_ovf;
        end
    end
    assign o_irq = irq_r;
    assign o_overflow = ovf_r;

    // pulse pin: active while running one-shot, inactive level by polarity
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pulse_output_pin <= 1'b0;
        end else if (!ctrl_r[osmt_pkg::B_TOUT_EN]) begin
            o_pulse_output_pin <= 1'b0;
        end else begin
            o_pulse_output_pin <= ctrl_r[osmt_pkg::B_OUT_POL]
                ^ (mode == osmt_pkg::MODE_ONESHOT && st_r == osmt_pkg::ST_RUN
                    && !os_underflow && !sw_reset);
        end
    end
endmodule
